// [ebo_arb.sv]
/*
  Distributed multiprocessor arbiter for one processor slot.
  Assumes request lines are active low and sampled synchronously to mclk.
*/
module ebo_arb (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration
  input wire logic [2:0] idx,
  input wire logic rotating_priority_select,
  // Request lines, active low, all processors
  input wire logic [ebo_pkg::NPROC-1:0] req_n,
  // Result
  output logic win
);
  logic [2:0] last_q, last_d;
  logic [2:0] winner;

  function automatic logic [2:0] pick(input logic [ebo_pkg::NPROC-1:0] r, input logic [2:0] start);
    logic [2:0] k;
    pick = 3'h0;
    for (int i = ebo_pkg::NPROC - 1; i >= 0; i--) begin
      k = 3'((32'(start) + 32'(i)) % ebo_pkg::NPROC);
      if (!r[k]) begin
        pick = k + 3'h1;
      end
    end
  endfunction

  always_comb begin
    // Fixed order starts at line 1; rotating starts after the previous winner.
    winner = pick(req_n, rotating_priority_select ? last_q : 3'h0);
    last_d = (winner != 3'h0) ? 3'(32'(winner) % ebo_pkg::NPROC) : last_q;
    win = (idx != ebo_pkg::IDX_SINGLE) && (winner == idx);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      last_q <= ebo_pkg::LAST_RST;
    end else begin
      last_q <= last_d;
    end
  end
endmodule

// [ebo_ctrl.sv]
/*
  External bus ownership control: host request and grant, suspend, host ready,
  and the multiprocessor request lines.
  Assumes all pins are synchronous to mclk; the pad ring resolves enables.
*/
module ebo_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Strap and configuration
  input wire logic [2:0] proc_index,
  input wire logic rotating_priority_select,
  input wire logic ready_drive_mode,
  // Host side, active low
  input wire logic host_bus_request_n,
  input wire logic host_cs_n,
  input wire logic host_bus_grant_n_i,
  output ebo_pkg::ebo_pin_t host_bus_grant_n,
  output ebo_pkg::ebo_pin_t host_wait_ready,
  // Suspend, active low
  input wire logic bus_suspend_in_n,
  // Processor request lines
  input wire logic [ebo_pkg::NPROC-1:0] proc_bus_request_n_i,
  output ebo_pkg::ebo_br_t proc_bus_request_n,
  // Core side
  input wire logic ext_req,
  input wire logic host_access_busy,
  output logic ext_done,
  output logic bus_out_en,
  output logic is_master
);
  ebo_pkg::ebo_state_t st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic rdy_mode_q, rdy_mode_d;
  logic float_q, float_d;
  logic own_req;
  logic win;
  logic [ebo_pkg::NPROC-1:0] req_seen;
  logic [ebo_pkg::NPROC-1:0] own_hot;

  function automatic logic [ebo_pkg::NPROC-1:0] onehot(input logic [2:0] i);
    onehot = '0;
    if (i != ebo_pkg::IDX_SINGLE && i <= ebo_pkg::IDX_MAX) begin
      onehot[i - 3'h1] = 1'b1;
    end
  endfunction

  always_comb begin
    own_hot = onehot(idx_q);
    own_req = ext_req && (st_q != ebo_pkg::ST_MASTER);
    req_seen = proc_bus_request_n_i;
    // Own line is read from what this slot drives, others from the pins.
    for (int i = 0; i < ebo_pkg::NPROC; i++) begin
      if (own_hot[i]) begin
        req_seen[i] = ~own_req;
      end
    end
  end

  ebo_arb u_arb (
    .mclk(mclk),
    .srst(srst),
    .idx(idx_q),
    .rotating_priority_select(rotating_priority_select),
    .req_n(req_seen),
    .win(win)
  );

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    rdy_mode_d = rdy_mode_q;
    // Strap is latched only in reset so a glitching pin cannot move ownership; mode is cleared in reset and follows its pin after.
    if (srst) begin
      idx_d = proc_index;
      rdy_mode_d = 1'b0;
    end else begin
      rdy_mode_d = ready_drive_mode;
    end
    case (st_q)
      ebo_pkg::ST_IDLE: begin
        // A grant pad held low by another owner means the host already has the bus.
        if (!host_bus_request_n || !host_bus_grant_n_i) begin
          st_d = ebo_pkg::ST_IDLE;
        end else if (ext_req && (idx_q == ebo_pkg::IDX_SINGLE || win)) begin
          st_d = ebo_pkg::ST_MASTER;
        end
      end
      ebo_pkg::ST_MASTER: begin
        if (!host_bus_request_n) begin
          st_d = ebo_pkg::ST_HOST;
        end else if (!ext_req) begin
          st_d = ebo_pkg::ST_IDLE;
        end
      end
      ebo_pkg::ST_HOST: begin
        if (host_bus_request_n) begin
          st_d = ebo_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = ebo_pkg::ST_IDLE;
      end
    endcase
    float_d = !bus_suspend_in_n;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ebo_pkg::ST_IDLE;
      float_q <= 1'b0;
    end else begin
      st_q <= st_d;
      float_q <= float_d;
    end
    idx_q <= idx_d;
    rdy_mode_q <= rdy_mode_d;
  end

  always_comb begin
    is_master = (st_q == ebo_pkg::ST_MASTER);
    bus_out_en = is_master && !float_q;
    // Suspend holds off completion until the cycle after it is released.
    ext_done = is_master && bus_suspend_in_n && !float_q;
    host_bus_grant_n.o = 1'b0;
    // Only the owner hands the bus over; others leave grant as an input.
    host_bus_grant_n.oe = (st_q == ebo_pkg::ST_HOST);
    proc_bus_request_n.o = '0;
    proc_bus_request_n.oe = own_req ? onehot(idx_q) : '0;
    // Driven only while selected and requesting; low for waits.
    host_wait_ready.o = !host_access_busy;
    host_wait_ready.oe = !host_cs_n && !host_bus_request_n
                         && (host_access_busy || rdy_mode_q);
  end

  property p_grant_hold;
    @(posedge mclk) disable iff (srst)
      (host_bus_grant_n.oe && !host_bus_request_n) |=> host_bus_grant_n.oe;
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant dropped early");

  property p_float;
    @(posedge mclk) disable iff (srst) !bus_suspend_in_n |=> !bus_out_en;
  endproperty
  a_float: assert property (p_float) else $error("bus driven during suspend");

  property p_stall;
    @(posedge mclk) disable iff (srst) ext_done |-> bus_suspend_in_n;
  endproperty
  a_stall: assert property (p_stall) else $error("access done during suspend");

  property p_release;
    @(posedge mclk) disable iff (srst)
      (is_master && !host_bus_request_n) |=> (!bus_out_en && host_bus_grant_n.oe);
  endproperty
  a_release: assert property (p_release) else $error("bus not released to host");

  property p_nohost_float;
    @(posedge mclk) disable iff (srst) host_bus_grant_n.oe |-> !bus_out_en;
  endproperty
  a_nohost_float: assert property (p_nohost_float) else $error("driving while host owns");

  property p_host_first;
    @(posedge mclk) disable iff (srst)
      ($rose(is_master)) |-> $past(host_bus_request_n);
  endproperty
  a_host_first: assert property (p_host_first) else $error("took bus over host");

  property p_grant_owner;
    @(posedge mclk) disable iff (srst) $rose(host_bus_grant_n.oe) |-> $past(is_master);
  endproperty
  a_grant_owner: assert property (p_grant_owner) else $error("non-master drove grant");

  property p_ready_gate;
    @(posedge mclk) disable iff (srst)
      host_wait_ready.oe |-> (!host_cs_n && !host_bus_request_n);
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("ready driven unselected");

  property p_ready_od;
    @(posedge mclk) disable iff (srst)
      (host_wait_ready.oe && !rdy_mode_q) |-> !host_wait_ready.o;
  endproperty
  a_ready_od: assert property (p_ready_od) else $error("ready drove high in open drain");

  property p_wait;
    @(posedge mclk) disable iff (srst)
      (!host_cs_n && !host_bus_request_n && host_access_busy)
        |-> (host_wait_ready.oe && !host_wait_ready.o);
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state");

  property p_own_line;
    @(posedge mclk) disable iff (srst)
      (proc_bus_request_n.oe & ~onehot(idx_q)) == '0;
  endproperty
  a_own_line: assert property (p_own_line) else $error("foreign request line driven");

  property p_grant_end;
    @(posedge mclk) disable iff (srst)
      (host_bus_grant_n.oe && host_bus_request_n) |=> !host_bus_grant_n.oe;
  endproperty
  a_grant_end: assert property (p_grant_end) else $error("grant kept after release");

  property p_idle_hold;
    @(posedge mclk) disable iff (srst)
      (!is_master && !host_bus_request_n) |=> !is_master;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("took bus while host asks");

  property p_ready_drive;
    @(posedge mclk) disable iff (srst)
      (host_wait_ready.oe && rdy_mode_q && !host_access_busy) |-> host_wait_ready.o;
  endproperty
  a_ready_drive: assert property (p_ready_drive) else $error("ready not driven high");

  property p_single;
    @(posedge mclk) disable iff (srst)
      (idx_q == ebo_pkg::IDX_SINGLE) |-> (proc_bus_request_n.oe == '0);
  endproperty
  a_single: assert property (p_single) else $error("request line driven when single");

  c_grant: cover property (@(posedge mclk) disable iff (srst) $rose(host_bus_grant_n.oe));
  c_master: cover property (@(posedge mclk) disable iff (srst) $rose(is_master));
  c_suspend: cover property (@(posedge mclk) disable iff (srst) is_master && !bus_suspend_in_n);
  c_wait: cover property (@(posedge mclk) disable iff (srst) host_wait_ready.oe);
  c_rotate: cover property (@(posedge mclk) disable iff (srst)
    rotating_priority_select && $rose(is_master));
endmodule

// [ebo_far.sv]
/*
  Far-side model: peer processors and host pull levels on the shared lines.
  Assumes the design's enables are already one-hot per line.
*/
module ebo_far (
  // Design drives
  input wire logic [5:0] own_o,
  input wire logic [5:0] own_oe,
  input wire logic grant_o,
  input wire logic grant_oe,
  // Peers pulling their request lines low
  input wire logic [5:0] peer_pull,
  // Pad levels
  output logic [5:0] req_pad_n,
  output logic grant_pad_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unused lines rest on board pull-ups; a driven line shows what its driver puts out.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      req_pad_n[i] = own_oe[i] ? own_o[i] : ~peer_pull[i];
    end
  end
  // Grant is pulled high unless the owning master drives it.
  assign grant_pad_n = grant_oe ? grant_o : 1'b1;
endmodule

// [ebo_pkg.sv]
/*
  Shared constants and carrier types for the external bus ownership block.
  Assumes one 40 MHz system clock and synchronous active-high reset.
*/
// What this block does
// - Suspend low floats address, data, selects and strobes from the next cycle.
// - A local access during suspend stalls and completes only after suspend releases.
// - Host requests the bus low; the master releases it and asserts grant low.
// - On handing the bus to a host, bus outputs are floated.
// - Host request beats every processor bus request.
// - Grant stays low until the host drops its request.
// - Only the current bus master drives host grant; others only monitor it.
// - Ready goes low to add waits to host accesses of memory or registers.
// - Ready is open drain after reset; a config bit makes it actively driven.
// - Ready is driven only while chip select and host request are both low.
// - Index 001 selects line 1, 010 line 2, upward; 000 is single processor.
// - Arbitration select high picks rotating priority, low picks fixed priority.
package ebo_pkg;
  localparam int NPROC = 6;
  localparam logic [2:0] IDX_SINGLE = 3'h0;
  localparam logic [2:0] IDX_MAX = 3'h6;
  localparam logic [2:0] LAST_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MASTER = 3'b010,
    ST_HOST = 3'b100
  } ebo_state_t;

  // Pin pair for an open-drain or three-state line.
  typedef struct packed {
    logic o;
    logic oe;
  } ebo_pin_t;

  typedef struct packed {
    logic [NPROC-1:0] o;
    logic [NPROC-1:0] oe;
  } ebo_br_t;
endpackage

// [external_bus_ownership_control_bench.sv]
/*
  Self-checking bench for the bus ownership block.
  Assumes ebo_pkg, ebo_ctrl and ebo_far are compiled first.
*/
module external_bus_ownership_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] idx = 3'h2;
  logic rps = 1'b0, mode = 1'b0, pmode = 1'b0, hbr_n = 1'b1, cs_n = 1'b1;
  logic sus_n = 1'b1, ext_req = 1'b0, busy = 1'b0, exp_oe;
  logic [5:0] peer = 6'h00, br_pad_n;
  logic grant_pad_n, ext_done, bus_out_en, is_master;
  ebo_pkg::ebo_pin_t grant, ready;
  ebo_pkg::ebo_br_t br;
  logic [31:0] rnd = 32'h584C;
  logic [23:0] notes[$];
  int bad_count = 0, cmp_count = 0;
  wire logic [11:0] obs = {is_master, bus_out_en, ext_done, grant.oe, ready.oe, ready.o, br.oe};

  always #12.5 mclk = ~mclk;

  ebo_ctrl u_dut (.mclk(mclk), .srst(srst), .proc_index(idx), .rotating_priority_select(rps),
    .ready_drive_mode(mode), .host_bus_request_n(hbr_n), .host_cs_n(cs_n),
    .host_bus_grant_n_i(grant_pad_n), .host_bus_grant_n(grant), .host_wait_ready(ready),
    .bus_suspend_in_n(sus_n), .proc_bus_request_n_i(br_pad_n), .proc_bus_request_n(br),
    .ext_req(ext_req), .host_access_busy(busy), .ext_done(ext_done),
    .bus_out_en(bus_out_en), .is_master(is_master));
  ebo_far u_far (.own_o(br.o), .own_oe(br.oe), .grant_o(grant.o), .grant_oe(grant.oe),
    .peer_pull(peer),
    .req_pad_n(br_pad_n), .grant_pad_n(grant_pad_n));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Expectation for the next falling edge: mask then value.
  task automatic note(input logic [11:0] m, input logic [11:0] e);
    notes.push_back({m, e});
  endtask

  task automatic chk(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: pad level wrong", $time);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 12 && obs[b] !== v; i++) @(negedge mclk);
    cmp_count++;
    if (obs[b] !== v) begin
      bad_count++;
      $display("unexpected at %0t: bit %0d never settled", $time, b);
    end
    @(posedge mclk);
  endtask

  always @(negedge mclk) begin
    if (notes.size() > 0) begin
      cmp_count++;
      if (((obs ^ notes[0][11:0]) & notes[0][23:12]) !== 12'h000) begin
        bad_count++;
        $display("unexpected at %0t: saw %h want %h", $time, obs, notes[0][11:0]);
      end
      void'(notes.pop_front());
    end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(3000 * 25);
    bad_count++;
    wrap_up();
  end

  initial begin
    tick(8);
    srst <= 1'b0;
    tick(2);
    // A peer on line 1 outranks index 2 under fixed priority.
    peer <= 6'h01;
    ext_req <= 1'b1;
    note(12'h83F, 12'h002);
    tick(1);
    chk(br_pad_n[1], 1'b0);
    note(12'h83F, 12'h002);
    tick(1);
    peer <= 6'h00;
    wait_bit(11, 1'b1);
    hbr_n <= 1'b0;
    note(12'hF00, 12'hE00);
    tick(1);
    note(12'hF00, 12'h100);
    tick(1);
    chk(grant_pad_n, 1'b0);
    cs_n <= 1'b0;
    busy <= 1'b1;
    note(12'hFC0, 12'h180);
    tick(1);
    busy <= 1'b0;
    note(12'hF80, 12'h100);
    tick(1);
    hbr_n <= 1'b1;
    cs_n <= 1'b1;
    note(12'h180, 12'h100);
    tick(1);
    note(12'h100, 12'h000);
    tick(1);
    wait_bit(9, 1'b1);
    sus_n <= 1'b0;
    tick(1);
    note(12'h600, 12'h000);
    tick(1);
    note(12'h600, 12'h000);
    tick(1);
    sus_n <= 1'b1;
    wait_bit(9, 1'b1);
    ext_req <= 1'b0;
    wait_bit(11, 1'b0);
    hbr_n <= 1'b0;
    ext_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      note(12'h900, 12'h000);
    end
    tick(1);
    ext_req <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      tick(1);
      rnd = xs(rnd);
      cs_n <= rnd[0];
      hbr_n <= rnd[1];
      busy <= rnd[2];
      mode <= rnd[3];
      rps <= rnd[4];
      exp_oe = !rnd[0] && !rnd[1] && (rnd[2] || pmode);
      note({5'h01, exp_oe, 6'h00}, {4'h0, exp_oe, !rnd[2], 6'h00});
      pmode = rnd[3];
    end
    tick(1);
    // Line 1 wins a fixed round, so the next rotating round starts just after it.
    hbr_n <= 1'b1;
    cs_n <= 1'b1;
    rps <= 1'b0;
    peer <= 6'h01;
    ext_req <= 1'b1;
    note(12'h800, 12'h000);
    tick(1);
    rps <= 1'b1;
    note(12'h800, 12'h000);
    tick(1);
    note(12'h800, 12'h800);
    tick(1);
    // A second reset restraps the slot as a single processor with no request line.
    srst <= 1'b1;
    idx <= 3'h0;
    rps <= 1'b0;
    peer <= 6'h00;
    ext_req <= 1'b0;
    tick(8);
    srst <= 1'b0;
    ext_req <= 1'b1;
    note(12'hE3F, 12'h000);
    tick(1);
    note(12'hE3F, 12'hE00);
    tick(2);
    wrap_up();
  end
endmodule
